// ### include/load_fault_pkg.sv
// Package of constants and types for the load access-error writeback unit
package load_fault_pkg;
  // Operation codes of the memory read instructions handled here
  typedef enum logic [2:0] {
    OP_MOVE     = 3'h0,
    OP_MOVE_ZX  = 3'h1,
    OP_MOVE_SX  = 3'h2,
    OP_TEST     = 3'h3,
    OP_OTHER    = 3'h7
  } load_op_e;

  // Access size codes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;

  // Condition-code bit positions
  localparam int CC_C = 0;
  localparam int CC_V = 1;
  localparam int CC_Z = 2;
  localparam int CC_N = 3;
  localparam int CC_X = 4;

  // Values after reset
  localparam logic       RST_FLAG  = 1'h0;
  localparam logic [4:0] RST_CCR   = 5'h00;
  localparam logic [2:0] RST_INDEX = 3'h0;
endpackage : load_fault_pkg

// ### core/load_access_error_writeback.sv
// Writeback and flag control for byte and word memory reads that may fault
// Summary of operation
// - On a read access error, destination data register keeps its old value.
// - On a read access error, condition-code flags keep their old values.
// - Suppression covers byte/word move, zero-extend, sign-extend and test reads.
// - While i_reset_on_error_en is set, any access error, read or write, requests a device reset.
module load_access_error_writeback #(
  parameter int DATA_W = 32,
  parameter int REG_N  = 8,
  parameter int IDX_W  = 3
) (
  input  wire logic                i_clk,
  input  wire logic                i_resetn,
  input  wire logic                i_reset_on_error_en,
  input  wire logic                i_rd_valid,
  input  wire logic [2:0]          i_rd_op,
  input  wire logic [1:0]          i_rd_size,
  input  wire logic [IDX_W-1:0]    i_rd_dest,
  input  wire logic [DATA_W-1:0]   i_rd_data,
  input  wire logic                i_rd_error,
  input  wire logic                i_wr_valid,
  input  wire logic                i_wr_error,
  input  wire logic [IDX_W-1:0]    i_rf_sel,
  output logic [DATA_W-1:0]        o_rf_data,
  output logic [4:0]               o_ccr,
  output logic                     o_reset_req,
  output logic                     o_access_exc,
  output logic                     o_retire
);

  // Decode results shared by the register file, flags and events
  logic              rd_fault;
  logic              wr_fault;
  logic              any_fault;
  logic              is_load;
  logic              ok;
  logic              writes_reg;

  // Shaped load value and the flag inputs taken from it
  // Word loads need DATA_W of at least 16
  logic [DATA_W-1:0] old;
  logic [DATA_W-1:0] ext;
  logic [DATA_W-1:0] merged;
  logic [DATA_W-1:0] result;
  logic              msb;
  logic              zero;

  // Register file, one entry per destination index
  logic [DATA_W-1:0] regs_q [REG_N];
  logic [DATA_W-1:0] regs_d [REG_N];

  // Condition codes, bit positions from the package
  logic [4:0]        ccr_q;
  logic [4:0]        ccr_d;

  // Event outputs
  logic              reset_req_q;
  logic              reset_req_d;
  logic              exc_q;
  logic              exc_d;
  logic              retire_q;
  logic              retire_d;

  // Register view
  logic [DATA_W-1:0] rf_data_q;
  logic [DATA_W-1:0] rf_data_d;

  // Decode; a read that faults must never count as a good load
  always_comb begin
    // Ops above test neither retire nor touch registers or flags
    is_load    = (i_rd_op == load_fault_pkg::OP_MOVE) ||
                 (i_rd_op == load_fault_pkg::OP_MOVE_ZX) ||
                 (i_rd_op == load_fault_pkg::OP_MOVE_SX) ||
                 (i_rd_op == load_fault_pkg::OP_TEST);
    rd_fault   = i_rd_valid && i_rd_error;
    wr_fault   = i_wr_valid && i_wr_error;
    // A read and a write fault in one cycle make a single event
    any_fault  = rd_fault || wr_fault;
    ok         = i_rd_valid && is_load && !i_rd_error;
    // Test reads set flags only and write no register
    writes_reg = ok && (i_rd_op != load_fault_pkg::OP_TEST);
  end

  // Shape the loaded value; bytes and words arrive in the low bits
  always_comb begin
    old    = regs_q[i_rd_dest];
    ext    = '0;
    merged = old;
    msb    = 1'h0;
    zero   = 1'h0;
    // Byte loads: sign from bit 7, zero test on the low byte
    if (i_rd_size == load_fault_pkg::SIZE_BYTE) begin
      msb         = i_rd_data[7];
      zero        = (i_rd_data[7:0] == 8'h00);
      ext[7:0]    = i_rd_data[7:0];
      merged[7:0] = i_rd_data[7:0];
      if (i_rd_op == load_fault_pkg::OP_MOVE_SX) begin
        ext[DATA_W-1:8] = {(DATA_W-8){msb}};
      end
    // Word loads: same pattern on the low half
    end else if (i_rd_size == load_fault_pkg::SIZE_WORD) begin
      msb          = i_rd_data[15];
      zero         = (i_rd_data[15:0] == 16'h0000);
      ext[15:0]    = i_rd_data[15:0];
      merged[15:0] = i_rd_data[15:0];
      if (i_rd_op == load_fault_pkg::OP_MOVE_SX) begin
        ext[DATA_W-1:16] = {(DATA_W-16){msb}};
      end
    end else begin
      // Full-width reads pass straight through
      msb    = i_rd_data[DATA_W-1];
      zero   = (i_rd_data == '0);
      ext    = i_rd_data;
      merged = i_rd_data;
    end
    // Plain moves keep the upper destination bits, the others extend
    result = (i_rd_op == load_fault_pkg::OP_MOVE) ? merged : ext;
  end

  // One entry per register; only the addressed entry takes a good load
  for (genvar g = 0; g < REG_N; g++) begin : g_reg
    always_comb begin
      regs_d[g] = regs_q[g];
      // A faulting read leaves the old contents in place
      if (writes_reg && (i_rd_dest == IDX_W'(g))) begin
        regs_d[g] = result;
      end
    end

    // Entries clear on reset with the rest of the core
    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        regs_q[g] <= '0;
      end else begin
        regs_q[g] <= regs_d[g];
      end
    end
  end

  // Flags follow a good load only; the extend bit is never touched
  always_comb begin
    ccr_d = ccr_q;
    if (ok) begin
      ccr_d[load_fault_pkg::CC_N] = msb;
      ccr_d[load_fault_pkg::CC_Z] = zero;
      // Overflow and carry always clear on a load
      ccr_d[load_fault_pkg::CC_V] = 1'h0;
      ccr_d[load_fault_pkg::CC_C] = 1'h0;
    end
  end

  // Flags register
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ccr_q <= load_fault_pkg::RST_CCR;
    end else begin
      ccr_q <= ccr_d;
    end
  end

  // Any fault, read or write, asks for a device reset while enabled
  always_comb begin
    reset_req_d = reset_req_q;
    if (any_fault && i_reset_on_error_en) begin
      reset_req_d = 1'h1;
    end
  end

  // Sticky, since only the device reset it asks for may clear it
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      reset_req_q <= load_fault_pkg::RST_FLAG;
    end else begin
      reset_req_q <= reset_req_d;
    end
  end

  // With reset off a fault raises the exception instead of retiring
  always_comb begin
    exc_d    = any_fault && !i_reset_on_error_en;
    // Retire only what really loaded; a faulting read never retires
    retire_d = ok;
  end

  // One-cycle event pulses
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      exc_q    <= load_fault_pkg::RST_FLAG;
      retire_q <= load_fault_pkg::RST_FLAG;
    end else begin
      exc_q    <= exc_d;
      retire_q <= retire_d;
    end
  end

  // View of one register; index is not range checked against REG_N
  always_comb begin
    rf_data_d = regs_q[i_rf_sel];
  end

  // View register; one edge of lag buys a flopped output
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rf_data_q <= '0;
    end else begin
      rf_data_q <= rf_data_d;
    end
  end

  // Outputs straight from their flops
  assign o_rf_data    = rf_data_q;
  assign o_ccr        = ccr_q;
  assign o_reset_req  = reset_req_q;
  assign o_access_exc = exc_q;
  assign o_retire     = retire_q;

endmodule : load_access_error_writeback

// ### sim/mem_rsp_model.sv
// Memory model for the read path
module mem_rsp_model (
  input  wire logic        i_clk,
  input  wire logic        i_req,
  input  wire logic        i_flt,
  input  wire logic [31:0] i_w,
  output logic             o_v = 1'h0,
  output logic             o_e = 1'h0,
  output logic [31:0]      o_d = 32'h0
);
  timeunit 1ns / 100ps;
  // Idle data inverts, so a stale word never passes for a fresh one
  always @(posedge i_clk) {o_v, o_e, o_d} <= {i_req, i_req & i_flt, i_req ? i_w : ~o_d};
endmodule : mem_rsp_model

// ### sim/load_fault_chk.sv
// Assertions on the load fault writeback ports
module load_fault_chk (
  input wire logic       i_clk,
  input wire logic       i_resetn,
  input wire logic       i_reset_on_error_en,
  input wire logic       i_rd_valid,
  input wire logic       i_rd_error,
  input wire logic       i_wr_valid,
  input wire logic       i_wr_error,
  input wire logic [4:0] o_ccr,
  input wire logic       o_reset_req,
  input wire logic       o_access_exc,
  input wire logic       o_retire
);
  timeunit 1ns / 100ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // A read that came back with an access error
  sequence rd_flt; i_rd_valid && i_rd_error; endsequence
  // A write that came back with an access error
  sequence wr_flt; i_wr_valid && i_wr_error; endsequence
  wr_reset_a: assert property (wr_flt ##0 i_reset_on_error_en |=> o_reset_req)
    else $error("no reset on write");
  wr_exc_a: assert property (wr_flt ##0 !i_reset_on_error_en |=> o_access_exc)
    else $error("no exception on write");
  ccr_kept_a: assert property (rd_flt |=> $stable(o_ccr)) else $error("flags moved");
  no_retire_a: assert property (rd_flt |=> !o_retire) else $error("fault retired");
  reset_req_a: assert property (rd_flt ##0 i_reset_on_error_en |=> o_reset_req)
    else $error("no reset");
  req_held_a: assert property (o_reset_req |=> o_reset_req) else $error("reset dropped");
  exc_taken_a: assert property (rd_flt ##0 !i_reset_on_error_en |=> o_access_exc)
    else $error("no exception");
endmodule : load_fault_chk
bind load_access_error_writeback load_fault_chk u_load_fault_chk (.*);

// ### sim/load_access_error_writeback_tb_top.sv
// Bench for the load fault writeback unit
module load_access_error_writeback_tb_top;
  timeunit 1ns / 100ps;
  logic clk = 1'h0, rstn = 1'h0, en = 1'h0, req = 1'h0, flt = 1'h0, rv, re, rtr, exc, rq;
  logic [4:0] cmd = 5'h0, ccr;
  logic wv = 1'h0, we = 1'h0;
  logic [31:0] w = 32'h0, dat, rf;
  int num_errors = 0, check_count = 0;
  always #2.5 clk = ~clk;
  mem_rsp_model u_mem_rsp_model (.i_clk(clk), .i_req(req), .i_flt(flt), .i_w(w), .o_v(rv),
    .o_e(re), .o_d(dat));
  load_access_error_writeback u_load_access_error_writeback (.i_clk(clk), .i_resetn(rstn),
    .i_reset_on_error_en(en), .i_rd_valid(rv), .i_rd_op(cmd[4:2]), .i_rd_size(cmd[1:0]),
    .i_rd_dest(3'h1), .i_rd_data(dat), .i_rd_error(re), .i_wr_valid(wv), .i_wr_error(we),
    .i_rf_sel(3'h1), .o_rf_data(rf), .o_ccr(ccr), .o_reset_req(rq), .o_access_exc(exc),
    .o_retire(rtr));
  task automatic chk(input logic [31:0] a, b);
    check_count++;
    if (a !== b) $display("[FAIL] %0t got %h want %h", $time, a, b);
    num_errors += int'(a !== b);
  endtask : chk
  task automatic conclude(input int extra);
    num_errors += extra;
    if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  // Pulses and flags at the answer edge; the register view lags one edge
  task automatic rdx(input logic [4:0] k, logic [31:0] d, logic f, logic [39:0] e);
    @(posedge clk) {cmd, w, flt, req} <= {k, d, f, 1'h1};
    @(posedge clk) req <= 1'h0;
    @(posedge clk) #1 chk({24'h0, rq, exc, rtr, ccr}, {24'h0, e[39:32]});
    @(posedge clk) #1 chk(rf, e[31:0]);
  endtask : rdx
  task automatic s_loads();
    rdx(5'h05, 32'h8001, 1'h0, 40'h28_0000_8001);
    rdx(5'h00, 32'hff00, 1'h0, 40'h24_0000_8000);
    rdx(5'h08, 32'h0080, 1'h0, 40'h28_ffff_ff80);
    rdx(5'h1c, 32'h0000, 1'h0, 40'h08_ffff_ff80);
  endtask : s_loads
  // Zero data would flip the flags and the register if it leaked through
  task automatic s_faults();
    for (int k = 0; k < 8; k++) rdx(5'(k / 2 * 4 + k % 2), 32'h0, 1'h1, 40'h48_ffff_ff80);
    @(posedge clk) en <= 1'h1;
    rdx(5'h05, 32'h0, 1'h1, 40'h88_ffff_ff80);
  endtask : s_faults
  // Write completion; its event shows at the edge that takes it
  task automatic wrx(input logic g, logic e, logic [7:0] x);
    @(posedge clk) {en, wv, we} <= {g, 1'h1, e};
    @(posedge clk) {wv, we} <= 2'h0;
    #1 chk({24'h0, rq, exc, rtr, ccr}, {24'h0, x});
  endtask : wrx
  // Software recovers by reset rather than trusting state after a fault
  task automatic s_restart();
    @(posedge clk) rstn <= 1'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk) #1 chk({24'h0, rq, exc, rtr, ccr}, 32'h0);
    chk(rf, 32'h0);
  endtask : s_restart
  // Write faults take the same two routes as read faults
  task automatic s_writes();
    wrx(1'h1, 1'h0, 8'h00);
    wrx(1'h0, 1'h1, 8'h40);
    wrx(1'h1, 1'h1, 8'h80);
  endtask : s_writes
  initial #5us conclude(1);
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'h1;
    s_loads();
    s_faults();
    s_restart();
    s_writes();
    conclude(0);
  end
endmodule : load_access_error_writeback_tb_top
